/* logic/ecf_pkg.sv */
package ecf_pkg;
   // Instruction decode
   localparam logic [6:0] ECF_OP_FORK = 7'h2E;
   localparam logic [6:0] ECF_OP_FRC = 7'h43;
   localparam int ECF_CHANNELS = 16;
   localparam int ECF_IP_W = 32;
   localparam int ECF_JIP_W = 16;
   localparam int ECF_MASK_W = 32;
   localparam logic [ECF_IP_W-1:0] ECF_IP_STEP = 32'h0000_0001;
   localparam logic [ECF_IP_W-1:0] ECF_IP_RESET = 32'h0000_0000;

   // Mask source selector of the channel-split instruction
   localparam logic [2:0] ECF_SRC_NULL = 3'h0;
   localparam logic [2:0] ECF_SRC_DMASK_LO = 3'h1;
   localparam logic [2:0] ECF_SRC_DMASK_HI = 3'h2;
   localparam logic [2:0] ECF_SRC_VMASK_LO = 3'h3;
   localparam logic [2:0] ECF_SRC_VMASK_HI = 3'h4;

   // Quarter select codes
   localparam logic [1:0] ECF_QTR_NONE = 2'h0;

   // Single-precision layout and special values
   localparam logic [7:0] ECF_F_EXP_MAX = 8'hFF;
   localparam logic [7:0] ECF_F_EXP_ZERO = 8'h00;
   localparam int ECF_F_BIAS = 127;
   localparam int ECF_F_MANT_W = 23;
   localparam int ECF_F_TINY_EXP = -24;
   localparam int ECF_FIX_W = 48;
   localparam int ECF_FIX_EXP_ADJ = 79;
   localparam logic [31:0] ECF_F_POS_ZERO = 32'h0000_0000;
   localparam logic [31:0] ECF_F_QNAN = 32'h7FC0_0000;
   localparam logic [31:0] ECF_F_BELOW_ONE = 32'h3F7F_FFFF;

   // APB register map
   localparam int ECF_APB_AW = 12;
   localparam logic [11:0] ECF_REG_CTRL = 12'h000;
   localparam logic [11:0] ECF_REG_STATUS = 12'h004;
   localparam logic [11:0] ECF_REG_EXECUTION_INSTR_POINTER = 12'h008;
   localparam int ECF_CTRL_ALT_BIT = 0;
   localparam int ECF_CTRL_ACC_BIT = 1;
   localparam int ECF_STAT_SPF_BIT = 0;
   localparam int ECF_STAT_JUMP_BIT = 1;
   localparam int ECF_STAT_ILL_BIT = 2;
   localparam logic [1:0] ECF_CTRL_RESET = 2'h0;
endpackage

/* logic/ecf_frac_unit.sv */
`timescale 1ns/10ps
module ecf_frac_unit
   import ecf_pkg::*;
(
   // Operand
   input wire logic [31:0] src_i,
   input wire logic alt_mode_i,
   input wire logic dst_int_i,
   // Result
   output logic [31:0] res_o
);
   logic sgn;
   logic [7:0] ex;
   logic [23:0] mant;
   int e;

   assign sgn = src_i[31];
   assign ex = src_i[30:23];
   assign mant = {1'b1, src_i[22:0]};
   assign e = int'(ex) - ECF_F_BIAS;

   always_comb begin
      logic [71:0] sh;
      logic [47:0] f;
      logic [47:0] norm;
      int p;
      sh = '0;
      f = '0;
      norm = '0;
      p = 0;
      res_o = ECF_F_POS_ZERO;
      if (ex == ECF_F_EXP_MAX) begin
         // Alternate mode: all-ones exponent is the largest finite magnitude
         res_o = alt_mode_i ? ECF_F_POS_ZERO : ECF_F_QNAN;
      end else if (ex == ECF_F_EXP_ZERO) begin
         res_o = ECF_F_POS_ZERO;
      end else if (e >= ECF_F_MANT_W) begin
         res_o = ECF_F_POS_ZERO;
      end else if (e < ECF_F_TINY_EXP) begin
         // 1 - tiny would round to 1.0, so clamp just below it
         res_o = sgn ? ECF_F_BELOW_ONE : src_i;
      end else begin
         sh = {48'h0, mant} << (e + 25);
         f = sh[47:0];
         if (sgn && f != '0) begin
            f = ~f + 48'h1;
         end
         for (int i = 0; i < ECF_FIX_W; i++) begin
            if (f[i]) begin
               p = i;
            end
         end
         norm = f << (47 - p);
         // Truncation keeps the result strictly below one
         if (f != '0) begin
            res_o = {1'b0, 8'(p + ECF_FIX_EXP_ADJ), norm[46:24]};
         end
      end
      // A fraction in [0,1) converts to integer zero
      if (dst_int_i) begin
         res_o = ECF_F_POS_ZERO;
      end
   end
endmodule

/* logic/ecf_ptr_lane.sv */
`timescale 1ns/10ps
module ecf_ptr_lane
   import ecf_pkg::*;
(
   // Current state
   input wire logic [ECF_IP_W-1:0] cur_i,
   input wire logic [ECF_IP_W-1:0] ip_i,
   input wire logic [ECF_IP_W-1:0] jip_ext_i,
   input wire logic spf_i,
   // Events
   input wire logic disp_i,
   input wire logic fork_i,
   input wire logic in_exec_i,
   input wire logic active_i,
   input wire logic br_i,
   input wire logic [ECF_IP_W-1:0] br_ptr_i,
   // Next pointer
   output logic [ECF_IP_W-1:0] nxt_o
);
   always_comb begin
      nxt_o = cur_i;
      if (disp_i) begin
         nxt_o = ip_i;
      end else if (fork_i) begin
         if (in_exec_i) begin
            nxt_o = active_i ? ip_i + ECF_IP_STEP : ip_i + jip_ext_i;
         end else if (spf_i) begin
            nxt_o = ip_i;
         end
      end else if (br_i && !spf_i) begin
         nxt_o = br_ptr_i;
      end
   end
endmodule

/* logic/ecf_exec_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Opcode 0x2E decodes as channel split selecting sixteen channels from a mask.
// - Null source sets the single-program-flow flag; no channel pointers change.
// - Mask source clears the flag; within the execution size, masked-off channels get IP+jump, others IP+1.
// - Active channels are the selected mask bits qualified by the predicate.
// - With no active channel, a relative jump by the encoded distance is taken.
// - Jump is a signed 16-bit chunk count in bits 15:0, added to IP pre-increment.
// - Leaving single-program-flow loads channel pointers beyond the execution size with the execution pointer.
// - Opcode 0x43 decodes as fraction, truncating toward minus infinity.
// - IEEE mode: inf and NaN give NaN, zeros and denormals +0, else [0,1).
// - Alternate mode: max magnitude, zeros, denormals give +0, else [0,1).
// - Fraction ignores saturation; only tiny negative inputs are clamped, to just below one.
// - With accumulator writes enabled, fraction also overwrites it with undefined data.
// - While single-program-flow is set, branches leave channel pointers unchanged.
module ecf_exec_top
   import ecf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ECF_APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Thread dispatch
   input wire logic disp_valid_i,
   input wire logic disp_simd32_i,
   input wire logic [ECF_IP_W-1:0] disp_ip_i,
   input wire logic [ECF_MASK_W-1:0] dmask_i,
   input wire logic [ECF_MASK_W-1:0] vmask_i,
   // Instruction issue
   input wire logic inst_valid_i,
   input wire logic [6:0] inst_opcode_i,
   input wire logic [2:0] inst_src_sel_i,
   input wire logic [1:0] inst_qtr_i,
   input wire logic [4:0] inst_exec_size_i,
   input wire logic inst_pred_en_i,
   input wire logic [ECF_CHANNELS-1:0] inst_pred_mask_i,
   input wire logic [ECF_JIP_W-1:0] inst_jip_i,
   input wire logic [31:0] inst_frc_src_i,
   input wire logic inst_dst_int_i,
   // Branch pointer updates from other control-flow logic
   input wire logic br_valid_i,
   input wire logic [ECF_IP_W-1:0] br_execution_instr_pointer_i,
   input wire logic [ECF_CHANNELS*ECF_IP_W-1:0] br_per_channel_instr_pointer_i,
   // Thread state
   output logic single_program_flow_flag_o,
   output logic [ECF_IP_W-1:0] execution_instr_pointer_o,
   output logic [ECF_CHANNELS*ECF_IP_W-1:0] per_channel_instr_pointer_o,
   output logic fork_jump_o,
   output logic illegal_o,
   // Fraction result
   output logic frc_valid_o,
   output logic [31:0] frc_data_o,
   output logic acc_we_o,
   output logic [31:0] acc_data_o
);
   logic [ECF_IP_W-1:0] per_channel_instr_pointer_r [ECF_CHANNELS];
   logic [ECF_IP_W-1:0] per_channel_instr_pointer_nxt [ECF_CHANNELS];
   logic [ECF_IP_W-1:0] execution_instr_pointer_r;
   logic [ECF_IP_W-1:0] execution_instr_pointer_nxt;
   logic spf_r;
   logic spf_nxt;
   logic [1:0] ctrl_r;
   logic jump_r;
   logic ill_r;
   logic ill_seen_r;
   logic frc_valid_r;
   logic [31:0] frc_data_r;
   logic acc_we_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // Decode
   wire is_fork = inst_valid_i && inst_opcode_i == ECF_OP_FORK;
   wire is_frc = inst_valid_i && inst_opcode_i == ECF_OP_FRC;
   wire src_null = inst_src_sel_i == ECF_SRC_NULL;
   wire src_known = inst_src_sel_i <= ECF_SRC_VMASK_HI;
   // Illegal forks leave pointers and the flag unchanged; only illegal_o and the sticky status bit are raised
   wire fork_bad = is_fork && (inst_qtr_i != ECF_QTR_NONE || !src_known);
   wire fork_ok = is_fork && !fork_bad && !disp_valid_i;
   wire fork_null = fork_ok && src_null;
   wire fork_mask = fork_ok && !src_null;

   // Mask half selection and predicate qualification
   wire [ECF_CHANNELS-1:0] sel_mask =
      inst_src_sel_i == ECF_SRC_DMASK_LO ? dmask_i[ECF_CHANNELS-1:0] :
      inst_src_sel_i == ECF_SRC_DMASK_HI ? dmask_i[ECF_MASK_W-1:ECF_CHANNELS] :
      inst_src_sel_i == ECF_SRC_VMASK_LO ? vmask_i[ECF_CHANNELS-1:0] :
      inst_src_sel_i == ECF_SRC_VMASK_HI ? vmask_i[ECF_MASK_W-1:ECF_CHANNELS] :
      '0;
   wire [ECF_CHANNELS-1:0] pred_q = inst_pred_en_i ? inst_pred_mask_i : '1;
   wire [ECF_CHANNELS-1:0] active = sel_mask & pred_q;
   wire [ECF_CHANNELS-1:0] exec_mask;
   wire none_active = (active & exec_mask) == '0;
   wire fork_jump = fork_mask && none_active;

   // Jump offset widened with its sign so backward targets work
   wire [ECF_IP_W-1:0] jip_ext =
      {{(ECF_IP_W-ECF_JIP_W){inst_jip_i[ECF_JIP_W-1]}}, inst_jip_i};
   wire [ECF_IP_W-1:0] lane_ip = disp_valid_i ? disp_ip_i : execution_instr_pointer_r;

   genvar gi;
   generate
      for (gi = 0; gi < ECF_CHANNELS; gi++) begin : g_lane
         assign exec_mask[gi] = gi < int'(inst_exec_size_i);
         ecf_ptr_lane u_lane (
            .cur_i(per_channel_instr_pointer_r[gi]),
            .ip_i(lane_ip),
            .jip_ext_i(jip_ext),
            .spf_i(spf_r),
            .disp_i(disp_valid_i),
            .fork_i(fork_mask),
            .in_exec_i(exec_mask[gi]),
            .active_i(active[gi]),
            .br_i(br_valid_i && !disp_valid_i && !fork_ok),
            .br_ptr_i(br_per_channel_instr_pointer_i[gi*ECF_IP_W +: ECF_IP_W]),
            .nxt_o(per_channel_instr_pointer_nxt[gi])
         );
         assign per_channel_instr_pointer_o[gi*ECF_IP_W +: ECF_IP_W] = per_channel_instr_pointer_r[gi];
         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               per_channel_instr_pointer_r[gi] <= ECF_IP_RESET;
            end else begin
               per_channel_instr_pointer_r[gi] <= per_channel_instr_pointer_nxt[gi];
            end
         end
      end
   endgenerate

   // Execution pointer and single-program-flow flag
   always_comb begin
      execution_instr_pointer_nxt = execution_instr_pointer_r;
      spf_nxt = spf_r;
      if (disp_valid_i) begin
         execution_instr_pointer_nxt = disp_ip_i;
         spf_nxt = disp_simd32_i;
      end else if (fork_ok) begin
         spf_nxt = src_null;
         execution_instr_pointer_nxt = fork_jump ? execution_instr_pointer_r + jip_ext : execution_instr_pointer_r + ECF_IP_STEP;
      end else if (br_valid_i) begin
         execution_instr_pointer_nxt = br_execution_instr_pointer_i;
      end else if (inst_valid_i && !fork_bad) begin
         execution_instr_pointer_nxt = execution_instr_pointer_r + ECF_IP_STEP;
      end
   end

   // Fraction datapath; saturation has no input here at all
   logic [31:0] frc_res;
   ecf_frac_unit u_frac (
      .src_i(inst_frc_src_i),
      .alt_mode_i(ctrl_r[ECF_CTRL_ALT_BIT]),
      .dst_int_i(inst_dst_int_i),
      .res_o(frc_res)
   );

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         execution_instr_pointer_r <= ECF_IP_RESET;
         spf_r <= 1'b0;
         jump_r <= 1'b0;
         ill_r <= 1'b0;
         frc_valid_r <= 1'b0;
         frc_data_r <= '0;
         acc_we_r <= 1'b0;
      end else begin
         execution_instr_pointer_r <= execution_instr_pointer_nxt;
         spf_r <= spf_nxt;
         jump_r <= fork_jump && !disp_valid_i;
         ill_r <= fork_bad;
         frc_valid_r <= is_frc;
         frc_data_r <= is_frc ? frc_res : frc_data_r;
         acc_we_r <= is_frc && ctrl_r[ECF_CTRL_ACC_BIT];
      end
   end

   // APB slave: zero wait states, unmapped addresses answer with an error
   wire apb_setup = psel_i && !penable_i;
   wire apb_wr = psel_i && penable_i && pready_r && pwrite_i;
   wire hit_ctrl = paddr_i == ECF_REG_CTRL;
   wire hit_stat = paddr_i == ECF_REG_STATUS;
   wire hit_execution_instr_pointer = paddr_i == ECF_REG_EXECUTION_INSTR_POINTER;
   wire hit_any = hit_ctrl || hit_stat || hit_execution_instr_pointer;
   wire [31:0] stat_word = {29'h0, ill_seen_r, jump_r, spf_r};
   wire [31:0] rd_word = hit_ctrl ? {30'h0, ctrl_r} :
                         hit_stat ? stat_word :
                         hit_execution_instr_pointer ? execution_instr_pointer_r : '0;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl_r <= ECF_CTRL_RESET;
         ill_seen_r <= 1'b0;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apb_setup;
         pslverr_r <= apb_setup && !hit_any;
         prdata_r <= (apb_setup && !pwrite_i) ? rd_word : '0;
         if (apb_wr && hit_ctrl) begin
            ctrl_r <= pwdata_i[1:0];
         end
         // A new illegal fork wins over a software clear in the same cycle
         if (fork_bad) begin
            ill_seen_r <= 1'b1;
         end else if (apb_wr && hit_stat && pwdata_i[ECF_STAT_ILL_BIT]) begin
            ill_seen_r <= 1'b0;
         end
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign single_program_flow_flag_o = spf_r;
   assign execution_instr_pointer_o = execution_instr_pointer_r;
   assign fork_jump_o = jump_r;
   assign illegal_o = ill_r;
   assign frc_valid_o = frc_valid_r;
   assign frc_data_o = frc_data_r;
   assign acc_we_o = acc_we_r;
   // Accumulator contents are undefined; the result word is reused
   assign acc_data_o = frc_data_r;
endmodule

/* bench/ecf_exec_checker.sv */
`timescale 1ns/10ps
module ecf_exec_checker
   import ecf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Requests
   input wire logic disp_valid_i,
   input wire logic inst_valid_i,
   input wire logic [6:0] inst_opcode_i,
   input wire logic [2:0] inst_src_sel_i,
   input wire logic [1:0] inst_qtr_i,
   input wire logic [ECF_JIP_W-1:0] inst_jip_i,
   input wire logic br_valid_i,
   // Thread state and results
   input wire logic single_program_flow_flag_o,
   input wire logic [ECF_IP_W-1:0] execution_instr_pointer_o,
   input wire logic [ECF_CHANNELS*ECF_IP_W-1:0] per_channel_instr_pointer_o,
   input wire logic fork_jump_o,
   input wire logic illegal_o,
   input wire logic frc_valid_o,
   input wire logic [31:0] frc_data_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   wire logic single_program_flow_flag = single_program_flow_flag_o;
   wire logic [ECF_IP_W-1:0] execution_instr_pointer = execution_instr_pointer_o;
   wire logic [ECF_CHANNELS*ECF_IP_W-1:0] per_channel_instr_pointer = per_channel_instr_pointer_o;
   wire logic is_fork = inst_valid_i && !disp_valid_i && inst_opcode_i == ECF_OP_FORK;
   wire logic fork_ok = is_fork && inst_qtr_i == ECF_QTR_NONE &&
      inst_src_sel_i <= ECF_SRC_VMASK_HI;
   wire logic fork_null = fork_ok && inst_src_sel_i == ECF_SRC_NULL;
   wire logic fork_mask = fork_ok && inst_src_sel_i != ECF_SRC_NULL;
   wire logic [ECF_IP_W-1:0] jip_ext = {{16{inst_jip_i[15]}}, inst_jip_i};
   wire logic frc_go = inst_valid_i && !disp_valid_i && !br_valid_i && inst_opcode_i == ECF_OP_FRC;

   AST_NULL_SETS_FLAG: assert property (fork_null |=> single_program_flow_flag)
      else $error("null split left flag clear");
   AST_NULL_KEEPS_PTRS: assert property (fork_null |=> $stable(per_channel_instr_pointer))
      else $error("null split moved channel pointers");
   AST_MASK_CLEARS_FLAG: assert property (fork_mask |=> !single_program_flow_flag)
      else $error("mask split left flag set");
   AST_JUMP_TARGET: assert property (fork_jump_o |-> execution_instr_pointer == $past(execution_instr_pointer) + $past(jip_ext))
      else $error("split jump target wrong");
   AST_JUMP_CAUSE: assert property (fork_jump_o |-> $past(fork_mask))
      else $error("jump without a mask split");
   AST_QTR_ILLEGAL: assert property (is_fork && inst_qtr_i != ECF_QTR_NONE |=> illegal_o)
      else $error("quarter select on split not flagged");
   AST_FRC_PULSE: assert property (frc_go |=> frc_valid_o)
      else $error("fraction result missing");
   AST_FRC_NONNEG: assert property (frc_valid_o |-> !frc_data_o[31])
      else $error("fraction result negative");
   AST_SPF_BRANCH: assert property (br_valid_i && single_program_flow_flag && !inst_valid_i && !disp_valid_i
      |=> $stable(per_channel_instr_pointer))
      else $error("branch moved pointers in single flow");
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
module tb;
   import ecf_pkg::*;
   typedef struct packed {
      logic [2:0] sel;
      logic [4:0] size;
      logic pen;
      logic [15:0] pm;
      logic [15:0] jip;
      logic ejmp;
      logic [31:0] eip;
   } ecf_row_t;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, rd;
   logic disp_valid_i = 1'b0, disp_simd32_i = 1'b0, er;
   logic [31:0] disp_ip_i = 32'h0, dmask_i = 32'h0000_00FF, vmask_i = 32'h5A5A_3C3C;
   logic inst_valid_i = 1'b0, inst_pred_en_i = 1'b0, inst_dst_int_i = 1'b0;
   logic [6:0] inst_opcode_i = 7'h00;
   logic [2:0] inst_src_sel_i = 3'h0;
   logic [1:0] inst_qtr_i = 2'h0;
   logic [4:0] inst_exec_size_i = 5'h10;
   logic [15:0] inst_pred_mask_i = 16'h0, inst_jip_i = 16'h0;
   logic [31:0] inst_frc_src_i = 32'h0, br_execution_instr_pointer_i = 32'h0;
   logic br_valid_i = 1'b0;
   logic [511:0] br_per_channel_instr_pointer_i = {16{32'hABCD_0123}};
   logic single_program_flow_flag, fjmp, ill, fv, awe, prdy, perr;
   logic [31:0] execution_instr_pointer, fdata, adata, prd;
   logic [511:0] per_channel_instr_pointer;
   logic m_spf, m_jmp;
   logic [31:0] m_ip;
   logic [31:0] m_pc [16];
   // Float sources only, never the accumulator
   logic [31:0] fin [7] = '{32'h3FC0_0000, 32'hBFA0_0000, 32'h7F80_0000, 32'h8000_0000,
      32'h0000_0001, 32'h7F7F_FFFF, 32'hFF7F_FFFF};
   logic [31:0] fex [7] = '{32'h3F00_0000, 32'h3F40_0000, 32'h7FC0_0000, 32'h0, 32'h0,
      32'h0, 32'h0};
   // Jump offsets are signed-word immediates; sources stay within the legal selectors
   ecf_row_t rows [7] = '{'{3'h1, 5'h08, 1'b0, 16'h0, 16'h0010, 1'b0, 32'h0000_0101},
      '{3'h2, 5'h10, 1'b0, 16'h0, 16'hFFFC, 1'b1, 32'h0000_00FD},
      '{3'h3, 5'h10, 1'b1, 16'h0F0F, 16'h0020, 1'b0, 32'h0000_00FE},
      '{3'h4, 5'h0C, 1'b0, 16'h0, 16'h0008, 1'b0, 32'h0000_00FF},
      '{3'h0, 5'h10, 1'b0, 16'h0, 16'h0, 1'b0, 32'h0000_0100},
      '{3'h3, 5'h10, 1'b1, 16'h0, 16'h0030, 1'b1, 32'h0000_0130},
      '{3'h0, 5'h10, 1'b0, 16'h0, 16'h0, 1'b0, 32'h0000_0131}};
   int n_fail = 0, n_checks = 0, cyc = 0;

   ecf_exec_top i_dut (.ref_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .disp_valid_i,
      .disp_simd32_i, .disp_ip_i, .dmask_i, .vmask_i, .inst_valid_i, .inst_opcode_i,
      .inst_src_sel_i, .inst_qtr_i, .inst_exec_size_i, .inst_pred_en_i, .inst_pred_mask_i,
      .inst_jip_i, .inst_frc_src_i, .inst_dst_int_i, .br_valid_i, .br_execution_instr_pointer_i, .br_per_channel_instr_pointer_i,
      .single_program_flow_flag_o(single_program_flow_flag), .execution_instr_pointer_o(execution_instr_pointer),
      .per_channel_instr_pointer_o(per_channel_instr_pointer), .fork_jump_o(fjmp), .illegal_o(ill),
      .frc_valid_o(fv), .frc_data_o(fdata), .acc_we_o(awe), .acc_data_o(adata));

   always #10 ref_clk_i = ~ref_clk_i;

   task automatic results();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs under a hundred cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (prdy !== 1'b1 && k < 16);
      rd = prd;
      er = perr;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      chk("apb answer", k < 16, 1'b1);
   endtask

   task automatic issue(input logic [6:0] op, input ecf_row_t r, input logic [1:0] q,
         input logic [31:0] fs);
      @(posedge ref_clk_i);
      inst_opcode_i <= op;
      inst_src_sel_i <= r.sel;
      inst_exec_size_i <= r.size;
      inst_pred_en_i <= r.pen;
      inst_pred_mask_i <= r.pm;
      inst_jip_i <= r.jip;
      inst_qtr_i <= q;
      inst_frc_src_i <= fs;
      inst_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      inst_valid_i <= 1'b0;
      #1;
   endtask

   task automatic model(input ecf_row_t r);
      logic [15:0] m;
      logic [31:0] tgt;
      m = r.sel[2] ? vmask_i[31:16] : r.sel == 3'h3 ? vmask_i[15:0] :
         r.sel == 3'h2 ? dmask_i[31:16] : dmask_i[15:0];
      m = r.pen ? m & r.pm : m;
      m = m & 16'((17'h1 << r.size) - 17'h1);
      tgt = m_ip + {{16{r.jip[15]}}, r.jip};
      if (r.sel == ECF_SRC_NULL) begin
         m_spf = 1'b1;
         m_jmp = 1'b0;
         m_ip = m_ip + 32'h1;
      end else begin
         for (int n = 0; n < 16; n++) begin
            if (n < r.size) m_pc[n] = m[n] ? m_ip + 32'h1 : tgt;
            else if (m_spf) m_pc[n] = m_ip;
         end
         m_jmp = (m == 16'h0);
         m_ip = m_jmp ? tgt : m_ip + 32'h1;
         m_spf = 1'b0;
      end
   endtask

   task automatic chk_state();
      chk("flag", single_program_flow_flag, m_spf);
      chk("execution_instr_pointer", execution_instr_pointer, m_ip);
      chk("jump", fjmp, m_jmp);
      for (int n = 0; n < 16; n++) chk("per_channel_instr_pointer", per_channel_instr_pointer[32*n +: 32], m_pc[n]);
   endtask

   initial begin
      repeat (10) @(posedge ref_clk_i);
      chk("reset flag", single_program_flow_flag, 1'b0);
      chk("reset execution_instr_pointer", execution_instr_pointer, 32'h0);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      disp_valid_i <= 1'b1;
      disp_simd32_i <= 1'b1;
      disp_ip_i <= 32'h0000_0100;
      @(posedge ref_clk_i);
      disp_valid_i <= 1'b0;
      #1;
      chk("dispatch flag", single_program_flow_flag, 1'b1);
      m_ip = 32'h0000_0100;
      m_spf = 1'b1;
      foreach (rows[i]) begin
         issue(ECF_OP_FORK, rows[i], ECF_QTR_NONE, 32'h0);
         model(rows[i]);
         chk_state();
         chk("row jump", fjmp, rows[i].ejmp);
         chk("row execution_instr_pointer", execution_instr_pointer, rows[i].eip);
      end
      // Flag is set here, so an outside branch must leave channel pointers alone
      @(posedge ref_clk_i);
      br_valid_i <= 1'b1;
      br_execution_instr_pointer_i <= 32'h0000_0200;
      @(posedge ref_clk_i);
      br_valid_i <= 1'b0;
      #1;
      m_ip = 32'h0000_0200;
      chk_state();
      issue(ECF_OP_FORK, rows[0], 2'h1, 32'h0);
      chk("illegal", ill, 1'b1);
      chk_state();
      apb(1'b0, ECF_REG_STATUS, 32'h0);
      chk("status", rd & 32'h5, 32'h5);
      apb(1'b1, ECF_REG_CTRL, 32'h2);
      for (int i = 0; i < 7; i++) begin
         if (i == 5) apb(1'b1, ECF_REG_CTRL, 32'h3);
         issue(ECF_OP_FRC, rows[0], ECF_QTR_NONE, fin[i]);
         chk("frc data", fdata, fex[i]);
         chk("frc valid", fv, 1'b1);
         chk("acc write", awe, 1'b1);
         chk("acc data", adata, fex[i]);
      end
      apb(1'b0, ECF_REG_CTRL, 32'h0);
      chk("ctrl", rd, 32'h3);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped", er, 1'b1);
      apb(1'b1, ECF_REG_STATUS, 32'h4);
      apb(1'b0, ECF_REG_STATUS, 32'h0);
      chk("ill clear", rd[ECF_STAT_ILL_BIT], 1'b0);
      apb(1'b1, ECF_REG_CTRL, 32'h0);
      inst_dst_int_i <= 1'b1;
      issue(ECF_OP_FRC, rows[0], ECF_QTR_NONE, fin[0]);
      chk("frc int", fdata, 32'h0);
      chk("acc idle", awe, 1'b0);
      // Mid-run reset, then a 16-channel dispatch and an outside branch with the flag clear
      @(posedge ref_clk_i);
      inst_dst_int_i <= 1'b0;
      srst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      #1;
      chk("reset flag", single_program_flow_flag, 1'b0);
      chk("reset execution_instr_pointer", execution_instr_pointer, 32'h0);
      chk("reset per_channel_instr_pointer", per_channel_instr_pointer[511:480], 32'h0);
      chk("reset pulse", {fv, ill, fjmp, awe}, 4'h0);
      @(posedge ref_clk_i);
      disp_valid_i <= 1'b1;
      disp_simd32_i <= 1'b0;
      disp_ip_i <= 32'h0000_0040;
      @(posedge ref_clk_i);
      disp_valid_i <= 1'b0;
      br_valid_i <= 1'b1;
      #1;
      chk("dispatch16 flag", single_program_flow_flag, 1'b0);
      chk("dispatch16 execution_instr_pointer", execution_instr_pointer, 32'h0000_0040);
      @(posedge ref_clk_i);
      br_valid_i <= 1'b0;
      #1;
      chk("branch execution_instr_pointer", execution_instr_pointer, 32'h0000_0200);
      chk("branch per_channel_instr_pointer", per_channel_instr_pointer[31:0], 32'hABCD_0123);
      results();
   end
endmodule

bind ecf_exec_top ecf_exec_checker i_chk (.ref_clk_i, .srst_i, .disp_valid_i, .inst_valid_i,
   .inst_opcode_i, .inst_src_sel_i, .inst_qtr_i, .inst_jip_i, .br_valid_i,
   .single_program_flow_flag_o, .execution_instr_pointer_o, .per_channel_instr_pointer_o,
   .fork_jump_o, .illegal_o, .frc_valid_o, .frc_data_o);
